// file: rtl/io_bus_pulse_and_break_port.sv
`timescale 1ns/1ps
`default_nettype none

module io_bus_pulse_and_break_port #(
  parameter int PASS_CYC = io_pulse_pkg::PASS_CYC
) (
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  // APB slave
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [11:0]              paddr,
  input  wire logic [31:0]              pwdata,
  output var  logic [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  // Processor side, same clock
  input  wire logic                     fetch_t4,
  input  wire logic [2:0]               opcode,
  input  wire logic [2:0]               io_transfer_instruction,
  input  wire logic                     time_pulse_five,
  input  wire logic                     time_state_two,
  input  wire logic                     time_state_five,
  input  wire logic                     run_flag,
  input  wire logic [11:0]              memory_bus,
  input  wire logic                     break_cycle,
  input  wire logic                     addr_accept_evt,
  input  wire logic                     wc_overflow_evt,
  input  wire logic                     io_preset,
  output logic                          transfer_pause_flag,
  output logic                          hold_time_state_five,
  output logic                          io_strobe,
  output var  logic [14:0]              break_address,
  output var  io_pulse_pkg::periph_in_s from_periph,
  // Peripheral pins
  input  wire io_pulse_pkg::periph_in_s periph_pins,
  output logic [2:0]                    buffered_io_pulse,
  output var  io_pulse_pkg::bus_out_s   to_periph
);

  // Counter is 8 bits and the strobe must fall inside the first pass
  if (PASS_CYC <= io_pulse_pkg::STROBE_CYC || PASS_CYC > 255) begin : g_bad_pass
    $error("PASS_CYC must exceed strobe point and fit 8 bits");
  end

  localparam int OFF_C    = io_pulse_pkg::OFF_CYC;
  localparam int STROBE_C = io_pulse_pkg::STROBE_CYC;
  localparam int PASS_C   = PASS_CYC;

  // Three-flop synchroniser with agreement filter
  io_pulse_pkg::periph_in_s sync1_r, sync2_r, sync3_r, pin_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_r <= '0;
      sync2_r <= '0;
      sync3_r <= '0;
      pin_r   <= '0;
    end else begin
      sync1_r <= periph_pins;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      // Keep the old value while the last two stages disagree
      pin_r   <= (pin_r & (sync2_r ^ sync3_r)) | (sync3_r & ~(sync2_r ^ sync3_r));
    end
  end
  assign from_periph = pin_r;

  // Pulse timing sequencer
  io_pulse_pkg::seq_state_e state_r, state_nxt;
  logic [7:0] cnt_r, cnt_nxt;
  logic [2:0] stage_r, stage_nxt;
  logic       pause_r, pause_nxt;
  logic       sample_r, sample_nxt;
  logic       strobe_r, strobe_nxt;
  logic       five_d_r;
  logic       ext_mem_r;

  wire five_fall   = five_d_r && !time_pulse_five;
  wire xfer_decode = fetch_t4 && (opcode == io_pulse_pkg::XFER_OPCODE);
  wire at_off      = (state_r == io_pulse_pkg::SEQ_PASS) && (cnt_r == 8'(OFF_C - 1));
  wire at_pass     = (state_r == io_pulse_pkg::SEQ_PASS) && (cnt_r == 8'(PASS_C - 1));
  wire at_strobe   = (state_r == io_pulse_pkg::SEQ_PASS) && stage_r[0] &&
                     (cnt_r == 8'(STROBE_C - 1));
  wire pulse_off   = at_off;
  wire digit_nz    = |io_transfer_instruction;

  always_comb begin
    state_nxt  = state_r;
    cnt_nxt    = cnt_r;
    stage_nxt  = stage_r;
    pause_nxt  = pause_r;
    sample_nxt = sample_r;
    strobe_nxt = 1'b0;
    unique case (state_r)
      io_pulse_pkg::SEQ_IDLE: begin
        if (xfer_decode) begin
          pause_nxt = 1'b1;
          stage_nxt = {1'b0, stage_r[1:0]};
          state_nxt = io_pulse_pkg::SEQ_ARMED;
        end
      end
      io_pulse_pkg::SEQ_ARMED: begin
        if (five_fall) begin
          stage_nxt  = io_pulse_pkg::STAGE_FIRST;
          sample_nxt = 1'b1;
          cnt_nxt    = '0;
          state_nxt  = io_pulse_pkg::SEQ_PASS;
        end
      end
      io_pulse_pkg::SEQ_PASS: begin
        cnt_nxt = cnt_r + 8'h01;
        if (at_strobe)
          strobe_nxt = digit_nz;
        if (pulse_off) begin
          sample_nxt = 1'b0;
          if (stage_r[2]) begin
            pause_nxt = 1'b0;
            stage_nxt = '0;
            state_nxt = io_pulse_pkg::SEQ_IDLE;
          end
        end
        if (at_pass) begin
          cnt_nxt    = '0;
          stage_nxt  = {stage_r[1:0], 1'b0};
          sample_nxt = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r  <= io_pulse_pkg::SEQ_IDLE;
      cnt_r    <= '0;
      stage_r  <= '0;
      pause_r  <= 1'b0;
      sample_r <= 1'b0;
      strobe_r <= 1'b0;
      five_d_r <= 1'b0;
    end else begin
      state_r  <= state_nxt;
      cnt_r    <= cnt_nxt;
      stage_r  <= stage_nxt;
      pause_r  <= pause_nxt;
      sample_r <= sample_nxt;
      strobe_r <= strobe_nxt;
      five_d_r <= time_pulse_five;
    end
  end

  assign buffered_io_pulse    = {3{sample_r}} & stage_r & io_transfer_instruction;
  assign transfer_pause_flag  = pause_r;
  assign hold_time_state_five = pause_r;
  assign io_strobe            = strobe_r;

  // Bus buffers, one register stage each
  io_pulse_pkg::bus_out_s out_r;
  logic preset_d_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_r         <= '0;
      preset_d_r    <= 1'b0;
      break_address <= '0;
    end else begin
      out_r.buffered_memory_bus <= memory_bus;
      out_r.dev_code_n          <= ~memory_bus[8:3];
      out_r.break_active        <= break_cycle;
      out_r.addr_accepted       <= addr_accept_evt;
      out_r.wc_overflow         <= wc_overflow_evt;
      out_r.time_state_two      <= time_state_two;
      out_r.time_state_five     <= time_state_five;
      out_r.run                 <= run_flag;
      out_r.bus_init_a          <= io_preset;
      out_r.bus_init_b          <= io_preset && !preset_d_r;
      preset_d_r                <= io_preset;
      // Without extended memory the field bits must not leak stale pins
      break_address <= {ext_mem_r ? pin_r.ext_addr : 3'h0, pin_r.break_addr};
    end
  end
  assign to_periph = out_r;

  // APB slave, zero wait states, read data staged in setup phase
  wire hit_ctrl   = (paddr == io_pulse_pkg::CTRL_ADDR);
  wire hit_status = (paddr == io_pulse_pkg::STATUS_ADDR);
  wire hit_flags  = (paddr == io_pulse_pkg::FLAGS_ADDR);
  wire hit_baddr  = (paddr == io_pulse_pkg::BADDR_ADDR);
  wire mapped     = hit_ctrl | hit_status | hit_flags | hit_baddr;
  wire setup_ph   = psel && !penable;
  wire wr_ctrl    = psel && penable && pwrite && hit_ctrl;

  wire [31:0] rd_mux =
    hit_ctrl   ? {31'h0, ext_mem_r} :
    hit_status ? {24'h0, strobe_r, sample_r, pause_r, stage_r, state_r} :
    hit_flags  ? {20'h0, pin_r.int_req, pin_r.skip, pin_r.clear_acc, pin_r.break_req,
                  pin_r.three_cycle, pin_r.inc_mb, pin_r.data_in, pin_r.ca_inc, 4'h0} :
    hit_baddr  ? {17'h0, break_address} : 32'h0;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata    <= '0;
      ext_mem_r <= io_pulse_pkg::CTRL_RESET;
    end else begin
      if (setup_ph && !pwrite)
        prdata <= rd_mux;
      if (wr_ctrl)
        ext_mem_r <= pwdata[io_pulse_pkg::CTRL_EXT_MEM_BIT];
    end
  end

  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // Assertions
  // Enable is seen high on OFF_CYC edges, first low edge comes OFF_CYC - 7 edges after the last of the eight counted
  localparam int OFF_LO  = io_pulse_pkg::OFF_CYC - 7;
  localparam int OFF_HI  = io_pulse_pkg::OFF_CYC - 7;

  sequence s_start;
    state_r == io_pulse_pkg::SEQ_ARMED && five_fall;
  endsequence
  sequence s_pass_open;
    sample_r && stage_r == io_pulse_pkg::STAGE_FIRST;
  endsequence

  property p_start;
    @(posedge clk) disable iff (!rst_n) s_start |=> s_pass_open;
  endproperty
  a_start: assert property (p_start) else $error("Start did not open first slot");

  property p_clear3;
    @(posedge clk) disable iff (!rst_n)
      $rose(pause_r) |-> !stage_r[2];
  endproperty
  a_clear3: assert property (p_clear3) else $error("Stage three not cleared");

  property p_pulse;
    @(posedge clk) disable iff (!rst_n)
      buffered_io_pulse[0] |-> sample_r && stage_r[0] && io_transfer_instruction[0];
  endproperty
  a_pulse: assert property (p_pulse) else $error("Pulse without its conditions");

  property p_off;
    @(posedge clk) disable iff (!rst_n)
      s_start ##1 s_pass_open |-> sample_r [*8] ##[OFF_LO:OFF_HI] !sample_r;
  endproperty
  a_off: assert property (p_off) else $error("Sample enable off time wrong");

  property p_strobe;
    @(posedge clk) disable iff (!rst_n)
      strobe_r |-> digit_nz && $past(at_strobe);
  endproperty
  a_strobe: assert property (p_strobe) else $error("Strobe at wrong time");

  property p_shift;
    @(posedge clk) disable iff (!rst_n)
      at_pass && !stage_r[2] |=> stage_r == {$past(stage_r[1:0]), 1'b0} && sample_r;
  endproperty
  a_shift: assert property (p_shift) else $error("Stage did not advance");

  property p_end;
    @(posedge clk) disable iff (!rst_n)
      pulse_off && stage_r[2] |=> !pause_r && state_r == io_pulse_pkg::SEQ_IDLE;
  endproperty
  a_end: assert property (p_end) else $error("Pause not cleared at end");

  property p_set;
    @(posedge clk) disable iff (!rst_n)
      state_r == io_pulse_pkg::SEQ_IDLE && xfer_decode |=> pause_r && hold_time_state_five;
  endproperty
  a_set: assert property (p_set) else $error("Pause not set on decode");

  // Skip the edge right after reset, when the buffer still holds its reset value
  property p_dev_n;
    @(posedge clk) disable iff (!rst_n)
      $past(rst_n) |-> to_periph.dev_code_n == ~$past(memory_bus[8:3]);
  endproperty
  a_dev_n: assert property (p_dev_n) else $error("Inverted device bits wrong");

  property p_init;
    @(posedge clk) disable iff (!rst_n)
      $rose(io_preset) |=> to_periph.bus_init_b ##1 !to_periph.bus_init_b;
  endproperty
  a_init: assert property (p_init) else $error("Init pulse wrong");

endmodule : io_bus_pulse_and_break_port

`default_nettype wire

// file: rtl/io_pulse_pkg.sv
package io_pulse_pkg;

  localparam int CLK_PERIOD_NS = 25;
  localparam int OFF_NS        = 650;
  localparam int STROBE_NS     = 750;
  localparam int PASS_NS       = 1200;
  localparam int OFF_CYC       = (OFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_CYC    = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PASS_CYC      = (PASS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam logic [2:0] XFER_OPCODE = 3'h6;
  localparam logic [2:0] STAGE_FIRST = 3'h1;

  localparam logic [11:0] CTRL_ADDR   = 12'h000;
  localparam logic [11:0] STATUS_ADDR = 12'h004;
  localparam logic [11:0] FLAGS_ADDR  = 12'h008;
  localparam logic [11:0] BADDR_ADDR  = 12'h00c;

  localparam int CTRL_EXT_MEM_BIT = 0;
  localparam logic CTRL_RESET     = 1'b0;

  typedef struct packed {
    logic [11:0] acc_data;
    logic        int_req;
    logic        skip;
    logic        clear_acc;
    logic        break_req;
    logic        three_cycle;
    logic        inc_mb;
    logic        data_in;
    logic        ca_inc;
    logic [11:0] break_addr;
    logic [2:0]  ext_addr;
    logic [11:0] break_data;
  } periph_in_s;

  typedef struct packed {
    logic [11:0] buffered_memory_bus;
    logic [5:0]  dev_code_n;
    logic        break_active;
    logic        addr_accepted;
    logic        wc_overflow;
    logic        time_state_two;
    logic        time_state_five;
    logic        run;
    logic        bus_init_a;
    logic        bus_init_b;
  } bus_out_s;

  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_ARMED,
    SEQ_PASS
  } seq_state_e;

endpackage : io_pulse_pkg

// file: verification/io_bus_pulse_and_break_port_tb.sv
`timescale 1ns/1ps
`default_nettype none
module io_bus_pulse_and_break_port_tb;
  localparam int PC = io_pulse_pkg::PASS_CYC;
  localparam int OC = io_pulse_pkg::OFF_CYC;
  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
  logic        fetch_t4, time_pulse_five, time_state_two, time_state_five, run_flag;
  logic        break_cycle, addr_accept_evt, wc_overflow_evt, io_preset;
  logic        transfer_pause_flag, hold_time_state_five, io_strobe;
  logic [2:0]  opcode, io_transfer_instruction, buffered_io_pulse;
  logic [11:0] paddr, memory_bus;
  logic [31:0] pwdata, prdata, rd;
  logic [14:0] break_address;
  int          errors = 0, checks_done = 0, cyc = 0, lp_ref = 0;
  io_pulse_pkg::periph_in_s from_periph, periph_pins, cmd;
  io_pulse_pkg::bus_out_s   to_periph;

  io_bus_pulse_and_break_port #(.PASS_CYC(PC)) uut (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fetch_t4(fetch_t4), .opcode(opcode), .io_transfer_instruction(io_transfer_instruction),
    .time_pulse_five(time_pulse_five), .time_state_two(time_state_two),
    .time_state_five(time_state_five), .run_flag(run_flag), .memory_bus(memory_bus),
    .break_cycle(break_cycle), .addr_accept_evt(addr_accept_evt),
    .wc_overflow_evt(wc_overflow_evt), .io_preset(io_preset),
    .transfer_pause_flag(transfer_pause_flag), .hold_time_state_five(hold_time_state_five),
    .io_strobe(io_strobe), .break_address(break_address), .from_periph(from_periph),
    .periph_pins(periph_pins), .buffered_io_pulse(buffered_io_pulse), .to_periph(to_periph)
  );

  periph_model partner (
    .clk(clk), .rst_n(rst_n), .io_pulse(buffered_io_pulse), .cmd(cmd), .pins(periph_pins)
  );

  always #12.5 clk = ~clk;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic wrap_up();
    $display("checks=%0d mismatches=%0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : wrap_up

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic run_xfer(input logic [2:0] d);
    int first[3];
    int hi[3];
    int stb;
    int lp;
    int hm;
    stb = 0;
    lp = 0;
    hm = 0;
    hi = '{0, 0, 0};
    first = '{0, 0, 0};
    @(posedge clk);
    io_transfer_instruction <= d;
    opcode <= 3'h6;
    fetch_t4 <= 1'b1;
    @(posedge clk);
    fetch_t4 <= 1'b0;
    time_pulse_five <= 1'b1;
    @(posedge clk);
    time_pulse_five <= 1'b0;
    for (int c = 0; c < 200; c++) begin
      @(posedge clk);
      #1;
      if (transfer_pause_flag === 1'b1) lp = c;
      if (hold_time_state_five !== transfer_pause_flag) hm++;
      if (io_strobe === 1'b1) stb++;
      for (int i = 0; i < 3; i++) begin
        if (buffered_io_pulse[i] === 1'b1) begin
          if (hi[i] == 0) first[i] = c;
          hi[i]++;
        end
      end
      if (buffered_io_pulse[1] === 1'b1 && hi[1] == 8) chk(32'(from_periph.acc_data), 32'h3c5);
    end
    if (d == 3'h0) lp_ref = lp;
    for (int i = 0; i < 3; i++) chk(32'(hi[i]), d[i] ? 32'(OC) : 32'h0);
    chk(32'(stb), (d != 3'h0) ? 32'h1 : 32'h0);
    chk(32'(lp), 32'(lp_ref));
    chk(32'(hm), 32'h0);
    chk(32'(transfer_pause_flag), 32'h0);
    if (d == 3'h7) begin
      chk(32'(first[1] - first[0]), 32'(PC));
      chk(32'(first[2] - first[1]), 32'(PC));
      chk(32'(lp - first[2]), 32'(OC - 1));
    end
  endtask : run_xfer

  initial begin
    {clk, rst_n, psel, penable, pwrite, fetch_t4, time_pulse_five, io_preset} = 8'h00;
    {time_state_two, time_state_five, run_flag, break_cycle} = 4'h0;
    {addr_accept_evt, wc_overflow_evt, opcode, io_transfer_instruction} = 8'h00;
    {paddr, memory_bus, pwdata} = 56'h0;
    cmd = '0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, io_pulse_pkg::CTRL_ADDR, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 12'h010, 32'h0);
    chk({rd[30:0], err}, 32'h1);
    $display("test registers done");
    @(posedge clk);
    cmd <= {12'h3c5, 8'hb5, 12'h7e1, 3'h5, 12'h9a2};
    repeat (8) @(posedge clk);
    chk(32'(from_periph[34:0]), 32'(cmd[34:0]));
    apb(1'b0, io_pulse_pkg::FLAGS_ADDR, 32'h0);
    chk(rd, 32'hb50);
    apb(1'b0, io_pulse_pkg::BADDR_ADDR, 32'h0);
    chk(rd, 32'h07e1);
    apb(1'b1, io_pulse_pkg::CTRL_ADDR, 32'h1);
    apb(1'b0, io_pulse_pkg::BADDR_ADDR, 32'h0);
    chk(rd, 32'h57e1);
    chk(32'(break_address), 32'h57e1);
    $display("test peripheral inputs done");
    @(posedge clk);
    memory_bus <= 12'ha5c;
    {break_cycle, addr_accept_evt, wc_overflow_evt, time_state_two} <= 4'hf;
    {time_state_five, run_flag, io_preset} <= 3'h3;
    @(posedge clk);
    #1;
    chk({to_periph.buffered_memory_bus, 2'h0, to_periph.dev_code_n}, 20'ha5c34);
    chk(32'(to_periph[7:0]), 32'hf7);
    @(posedge clk);
    #1;
    chk({to_periph.bus_init_a, to_periph.bus_init_b}, 2'h2);
    @(posedge clk);
    memory_bus <= 12'h5a3;
    {break_cycle, addr_accept_evt, wc_overflow_evt, time_state_two} <= 4'h0;
    {time_state_five, run_flag, io_preset} <= 3'h4;
    @(posedge clk);
    #1;
    chk({to_periph.buffered_memory_bus, 2'h0, to_periph.dev_code_n}, 20'h5a30b);
    chk(32'(to_periph[7:0]), 32'h08);
    $display("test output buffers done");
    @(posedge clk);
    opcode <= 3'h5;
    fetch_t4 <= 1'b1;
    @(posedge clk);
    fetch_t4 <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk(32'(transfer_pause_flag), 32'h0);
    apb(1'b0, io_pulse_pkg::STATUS_ADDR, 32'h0);
    chk(rd, 32'h0);
    for (int d = 0; d < 8; d++) run_xfer(3'(d));
    $display("test pulse sequence done");
    wrap_up();
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      wrap_up();
    end
  end
endmodule : io_bus_pulse_and_break_port_tb
`default_nettype wire

// file: verification/periph_model.sv
`timescale 1ns/1ps
`default_nettype none
module periph_model (
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  input  wire logic [2:0]               io_pulse,
  input  wire io_pulse_pkg::periph_in_s cmd,
  output var  io_pulse_pkg::periph_in_s pins
);
  io_pulse_pkg::periph_in_s drive_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      drive_r <= '0;
    end else begin
      drive_r <= cmd;
    end
  end

  // Data lines only valid during a pulse; inverted otherwise so stale data is caught
  always_comb begin
    pins = drive_r;
    if (io_pulse == 3'h0) begin
      pins.acc_data = ~drive_r.acc_data;
    end
  end
endmodule : periph_model
`default_nettype wire
